/* verilog/vpsc_pkg.sv */
// package: register map, field layout and reset values of the power stage config slice
package vpsc_pkg;
  // register offsets
  localparam logic [7:0] VPSC_OFS_TARGET_LOWER = 8'h7A;
  localparam logic [7:0] VPSC_OFS_TARGET_UPPER = 8'h7B;
  localparam logic [7:0] VPSC_OFS_CURRENT      = 8'h80;
  localparam logic [7:0] VPSC_OFS_CABLE_COMP   = 8'h81;
  localparam logic [7:0] VPSC_OFS_ILIM         = 8'h82;
  localparam logic [7:0] VPSC_OFS_CONV         = 8'h83;
  localparam logic [7:0] VPSC_OFS_WDOG         = 8'h84;
  // reset values
  localparam logic [7:0] VPSC_RST_TARGET_UPPER = 8'h00;
  localparam logic [5:0] VPSC_RST_GAIN         = 6'h00;
  localparam logic [7:0] VPSC_RST_ILIM         = 8'h80;
  localparam logic [2:0] VPSC_RST_SLOPE        = 3'h3;
  localparam logic [1:0] VPSC_RST_FSW          = 2'h2;
  localparam logic       VPSC_RST_SYNC_DIR     = 1'b1;
  localparam logic [1:0] VPSC_RST_SPREAD       = 2'h0;
  localparam logic [1:0] VPSC_RST_WDOG         = 2'h0;
  localparam logic [15:0] VPSC_RST_SETPOINT    = 16'h0000;
  // field widths
  localparam int VPSC_GAIN_W = 6;
  localparam int VPSC_MEAS_W = 7;

  // converter setup register layout, msb first
  typedef struct packed {
    logic [2:0] slope_ramp_select;
    logic [1:0] switching_frequency_select;
    logic       sync_dir;
    logic [1:0] spread_select;
  } vpsc_conv_t;

  // register access request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vpsc_req_t;

  // held configuration toward the analog side
  typedef struct packed {
    logic [15:0] setpoint;
    logic [5:0]  gain;
    logic [7:0]  current_limit_code;
    vpsc_conv_t  conv;
    logic [1:0]  watchdog_timeout_select;
  } vpsc_cfg_t;
endpackage : vpsc_pkg

/* verilog/vpsc_regs.sv */
// module: power stage configuration register slice
// Functional notes
// - target is 16 bits, low and high byte; this slice stores the high byte
// - output setpoint follows stored target only on source-nondefault command
// - current register is read-only, 7-bit code, 50 mA per count
// - current register bit 7 always reads zero
// - cable compensation gain is 6 bits in low bits, resets to zero
// - current-limit target is 8-bit, 25 mA steps, resets to 0x80
// - slope field bits 7:5, 100 to 800 mV, resets to 011
// - switching frequency field bits 4:3, resets to 10
// - sync direction bit 2: zero output, one input, resets to input
// - spread-spectrum field bits 1:0, resets to disabled
// - watchdog timeout field bits 1:0, resets to one second
`timescale 1ns/100ps
`default_nettype none
module vpsc_regs
  import vpsc_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire vpsc_req_t              req,
  input  wire logic                   req_valid,
  output logic [7:0]                  rdata,
  input  wire logic [7:0]             output_target_lower,
  input  wire logic                   source_nondefault_command,
  input  wire logic [VPSC_MEAS_W-1:0] current_meas,
  output vpsc_cfg_t                   cfg,
  output logic                        sync_pin_o,
  output logic                        sync_pin_oe
);
  logic [7:0]  output_target_upper_q;
  logic [5:0]  gain_q;
  logic [7:0]  ilim_q;
  vpsc_conv_t  conv_q;
  logic [1:0]  wdog_q;
  logic [15:0] setpoint_q;
  logic [7:0]  rdata_q;

  // write strobe for one offset
  function automatic logic wr_hit(input vpsc_req_t r, input logic v, input logic [7:0] ofs);
    wr_hit = v && r.wr && (r.addr == ofs);
  endfunction : wr_hit

  // upper target byte store
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      output_target_upper_q <= VPSC_RST_TARGET_UPPER;
    end else if (wr_hit(req, req_valid, VPSC_OFS_TARGET_UPPER)) begin
      output_target_upper_q <= req.wdata;
    end
  end

  // setpoint takes the full target only on the command
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      setpoint_q <= VPSC_RST_SETPOINT;
    end else if (source_nondefault_command) begin
      setpoint_q <= {output_target_upper_q, output_target_lower};
    end
  end

  // cable compensation gain, upper bits dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gain_q <= VPSC_RST_GAIN;
    end else if (wr_hit(req, req_valid, VPSC_OFS_CABLE_COMP)) begin
      gain_q <= req.wdata[VPSC_GAIN_W-1:0];
    end
  end

  // current limit target
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ilim_q <= VPSC_RST_ILIM;
    end else if (wr_hit(req, req_valid, VPSC_OFS_ILIM)) begin
      ilim_q <= req.wdata;
    end
  end

  // converter setup fields
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conv_q <= '{VPSC_RST_SLOPE, VPSC_RST_FSW, VPSC_RST_SYNC_DIR, VPSC_RST_SPREAD};
    end else if (wr_hit(req, req_valid, VPSC_OFS_CONV)) begin
      conv_q <= vpsc_conv_t'(req.wdata);
    end
  end

  // watchdog timeout select
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wdog_q <= VPSC_RST_WDOG;
    end else if (wr_hit(req, req_valid, VPSC_OFS_WDOG)) begin
      wdog_q <= req.wdata[1:0];
    end
  end

  // registered read data, one cycle after the request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (req_valid && !req.wr) begin
      case (req.addr)
        VPSC_OFS_TARGET_UPPER: rdata_q <= output_target_upper_q;
        VPSC_OFS_CURRENT:      rdata_q <= {1'b0, current_meas};
        VPSC_OFS_CABLE_COMP:   rdata_q <= {2'b00, gain_q};
        VPSC_OFS_ILIM:         rdata_q <= ilim_q;
        VPSC_OFS_CONV:         rdata_q <= conv_q;
        VPSC_OFS_WDOG:         rdata_q <= {6'h00, wdog_q};
        default:               rdata_q <= 8'h00;
      endcase
    end
  end

  // outputs
  assign rdata       = rdata_q;
  assign cfg         = '{setpoint_q, gain_q, ilim_q, conv_q, wdog_q};
  assign sync_pin_oe = ~conv_q.sync_dir;
  assign sync_pin_o  = 1'b0;

  // checks
  curr_msb_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && !req.wr && req.addr == VPSC_OFS_CURRENT |=> rdata[7] == 1'b0 && rdata[6:0] == $past(current_meas))
    else $error("current read msb or value wrong");
  setpoint_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !source_nondefault_command |=> $stable(cfg.setpoint))
    else $error("setpoint moved without command");
  setpoint_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    source_nondefault_command |=> cfg.setpoint == {$past(output_target_upper_q), $past(output_target_lower)})
    else $error("setpoint not loaded from target");
  gain_pad_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && !req.wr && req.addr == VPSC_OFS_CABLE_COMP |=> rdata[7:6] == 2'b00)
    else $error("gain upper bits not zero");
  wdog_pad_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && !req.wr && req.addr == VPSC_OFS_WDOG |=> rdata[7:2] == 6'h00)
    else $error("watchdog upper bits not zero");
  ilim_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && req.wr && req.addr == VPSC_OFS_ILIM |=> cfg.current_limit_code == $past(req.wdata))
    else $error("limit write lost");
  conv_reset_a: assert property (@(posedge mclk)
    !rst_n |=> cfg.conv.slope_ramp_select == VPSC_RST_SLOPE
      && cfg.conv.switching_frequency_select == VPSC_RST_FSW
      && cfg.conv.sync_dir == VPSC_RST_SYNC_DIR
      && cfg.conv.spread_select == VPSC_RST_SPREAD)
    else $error("converter setup reset wrong");
  sync_dir_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sync_pin_oe == !cfg.conv.sync_dir)
    else $error("sync direction wrong");
  gain_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req_valid && req.wr && req.addr == VPSC_OFS_CABLE_COMP) |=> $stable(cfg.gain))
    else $error("gain changed without write");

  // target bytes: upper write lands and reads back, lower offset reads zero
  upper_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && req.wr && req.addr == VPSC_OFS_TARGET_UPPER
      |=> output_target_upper_q == $past(req.wdata))
    else $error("upper target write lost");
  upper_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && !req.wr && req.addr == VPSC_OFS_TARGET_UPPER
      |=> rdata == $past(output_target_upper_q))
    else $error("upper target read wrong");
  lower_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && !req.wr && req.addr == VPSC_OFS_TARGET_LOWER |=> rdata == 8'h00)
    else $error("lower target offset read not zero");

  // current reading never exceeds the 7-bit code range
  curr_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && !req.wr && req.addr == VPSC_OFS_CURRENT |=> rdata <= 8'h7F)
    else $error("current read out of range");

  // gain field: write, readback and reset
  gain_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && req.wr && req.addr == VPSC_OFS_CABLE_COMP
      |=> cfg.gain == $past(req.wdata[VPSC_GAIN_W-1:0]))
    else $error("gain write lost");
  gain_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && !req.wr && req.addr == VPSC_OFS_CABLE_COMP
      |=> rdata[VPSC_GAIN_W-1:0] == $past(cfg.gain))
    else $error("gain read wrong");
  gain_reset_a: assert property (@(posedge mclk)
    !rst_n |=> cfg.gain == VPSC_RST_GAIN)
    else $error("gain reset wrong");

  // current limit: reset value and hold between writes
  ilim_reset_a: assert property (@(posedge mclk)
    !rst_n |=> cfg.current_limit_code == VPSC_RST_ILIM)
    else $error("limit reset wrong");
  ilim_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req_valid && req.wr && req.addr == VPSC_OFS_ILIM)
      |=> $stable(cfg.current_limit_code))
    else $error("limit changed without write");

  // converter setup: whole byte lands and holds
  conv_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && req.wr && req.addr == VPSC_OFS_CONV |=> cfg.conv == $past(req.wdata))
    else $error("converter setup write lost");
  conv_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req_valid && req.wr && req.addr == VPSC_OFS_CONV) |=> $stable(cfg.conv))
    else $error("converter setup changed without write");

  // watchdog select: write, reset and hold
  wdog_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && req.wr && req.addr == VPSC_OFS_WDOG
      |=> cfg.watchdog_timeout_select == $past(req.wdata[1:0]))
    else $error("watchdog write lost");
  wdog_reset_a: assert property (@(posedge mclk)
    !rst_n |=> cfg.watchdog_timeout_select == VPSC_RST_WDOG)
    else $error("watchdog reset wrong");
  wdog_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req_valid && req.wr && req.addr == VPSC_OFS_WDOG)
      |=> $stable(cfg.watchdog_timeout_select))
    else $error("watchdog changed without write");

  // setpoint cleared by reset
  setpoint_reset_a: assert property (@(posedge mclk)
    !rst_n |=> cfg.setpoint == VPSC_RST_SETPOINT)
    else $error("setpoint reset wrong");

  // read data stands until the next read
  rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req_valid && !req.wr) |=> $stable(rdata))
    else $error("read data moved without read");

  // sync drive value is tied low by this slice
  sync_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sync_pin_o == 1'b0)
    else $error("sync drive value not low");
endmodule : vpsc_regs
`default_nettype wire

/* bench/vpsc_host_model.sv */
// host model: port manager issuing register accesses
`timescale 1ns/100ps
`default_nettype none
module vpsc_host_model
  import vpsc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdata,
  output var vpsc_req_t   req,
  output var logic        req_valid
);
  // idle until the first access
  initial begin
    req       = '0;
    req_valid = 1'b0;
  end
  // one access, taken at the edge after it is raised
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge mclk) #1;
    req       = '{wr: w, addr: a, wdata: d};
    req_valid = 1'b1;
    @(posedge mclk) #1;
    req_valid = 1'b0;
    req.wdata = ~d; // stale data does not linger
    q         = rdata;
  endtask : access
endmodule : vpsc_host_model
`default_nettype wire

/* bench/vpsc_regs_tb_top.sv */
// testbench: register slice driven through the host model
`timescale 1ns/100ps
`default_nettype none
module vpsc_regs_tb_top;
  logic                mclk, rst_n, req_valid, cmd, sync_oe, sync_o;
  logic [7:0]          rdata, lower, rd, v;
  logic [6:0]          meas;
  vpsc_pkg::vpsc_req_t req;
  vpsc_pkg::vpsc_cfg_t cfg;
  int                  n_mismatch = 0;
  int                  compares = 0;
  vpsc_regs vpsc_regs_inst (.mclk(mclk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
    .rdata(rdata), .output_target_lower(lower), .source_nondefault_command(cmd),
    .current_meas(meas), .cfg(cfg), .sync_pin_o(sync_o), .sync_pin_oe(sync_oe));
  vpsc_host_model vpsc_host_model_inst (.mclk(mclk), .rdata(rdata), .req(req),
    .req_valid(req_valid));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    vpsc_host_model_inst.access(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    vpsc_host_model_inst.access(1'b0, a, 8'h00, rd);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd});
  endtask : rdc
  // reset values of every register and held field
  task automatic defaults();
    rdc(8'h7B, 8'h00);
    rdc(8'h81, 8'h00);
    rdc(8'h82, 8'h80);
    rdc(8'h83, 8'h74);
    rdc(8'h84, 8'h00);
    chk("setpoint", 16'h0000, cfg.setpoint);
    chk("sync oe", 16'h0000, {15'h0, sync_oe});
    chk("sync out", 16'h0000, {15'h0, sync_o});
    chk("watchdog", 16'h0000, {14'h0, cfg.watchdog_timeout_select});
  endtask : defaults
  // main sequence
  initial begin
    rst_n = 1'b0;
    cmd   = 1'b0;
    lower = 8'h3C;
    meas  = 7'h7F;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    defaults();
    wr(8'h7B, 8'hA5);
    wr(8'h7A, 8'h11);
    rdc(8'h7A, 8'h00);
    chk("setpoint", 16'h0000, cfg.setpoint);
    @(posedge mclk) #1 cmd = 1'b1;
    @(posedge mclk) #1 cmd = 1'b0;
    chk("setpoint", 16'hA53C, cfg.setpoint);
    // reading taken as valid: sourcing with the voltage monitor off
    rdc(8'h80, 8'h7F);
    wr(8'h80, 8'hFF);
    meas = 7'h15;
    rdc(8'h80, 8'h15);
    wr(8'h81, 8'hFF);
    rdc(8'h81, 8'h3F);
    wr(8'h84, 8'hFF);
    rdc(8'h84, 8'h03);
    chk("watchdog", 16'h0003, {14'h0, cfg.watchdog_timeout_select});
    wr(8'h82, 8'h28);
    rdc(8'h82, 8'h28);
    wr(8'h82, 8'hFE);
    chk("limit", 16'h00FE, {8'h00, cfg.current_limit_code});
    // every code of each converter field
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], i[1:0], i[0], i[1:0]};
      wr(8'h83, v);
      chk("conv", {8'h00, v}, {8'h00, cfg.conv});
      chk("sync oe", {15'h0, ~v[2]}, {15'h0, sync_oe});
    end
    rdc(8'h83, 8'hFF);
    rdc(8'h90, 8'h00);
    // reset in mid-run
    @(posedge mclk) #1 rst_n = 1'b0;
    @(posedge mclk) #1 rst_n = 1'b1;
    defaults();
    // command after reset takes the cleared upper byte
    @(posedge mclk) #1 cmd = 1'b1;
    @(posedge mclk) #1 cmd = 1'b0;
    chk("setpoint", 16'h003C, cfg.setpoint);
    stop_test();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
endmodule : vpsc_regs_tb_top
`default_nettype wire
